// >>> rtl/pioc_defines.svh
`ifndef PIOC_DEFINES_SVH
`define PIOC_DEFINES_SVH
`define PIOC_ADDR_TUNING 4'h0
`define PIOC_ADDR_STATUS 4'h1
`define PIOC_TUNE_RST 8'h00
`define PIOC_BIT_LF_SRC 7
`define PIOC_BIT_MULT_EN 6
`define PIOC_TRIM_MSB 5
`define PIOC_TRIM_LSB 0
`define PIOC_TRIM_OFFSET 6'h20
`define PIOC_LOCK_TIME_US 2000
`define PIOC_CLK_FREQ_MHZ 20
`define PIOC_NODE48_DIV 2'h2
`define PIOC_USB_LS_DIV 4'h8
`define PIOC_LF_DIV 9'h100
`define PIOC_CORE_CLOCK_DIVIDER_SELECT_NONE 2'h3
`define PIOC_CORE_CLOCK_DIVIDER_SELECT_TWO 2'h2
`define PIOC_CORE_CLOCK_DIVIDER_SELECT_THREE 2'h1
`define PIOC_INTERNAL_FREQ_SELECT_LOW 3'h0
`endif

// >>> rtl/pioc_pkg.sv
package pioc_pkg;

    typedef enum logic [2:0] {
        PIOC_CRYSTAL_MULT,
        PIOC_EXT_CLOCK_MULT,
        PIOC_INTERNAL_MULT,
        PIOC_INTERNAL_MULT_CLKOUT,
        PIOC_CRYSTAL,
        PIOC_EXT_CLOCK,
        PIOC_INTERNAL,
        PIOC_INTERNAL_CLKOUT
    } pioc_osc_mode_t;

    typedef struct packed {
        pioc_osc_mode_t mode;
        logic [2:0] prescale_sel;
        logic [1:0] core_clock_divider_select;
        logic [2:0] internal_freq_select;
        logic pwrt_en;
        logic fscm_en;
        logic wdt_en;
        logic twospd_en;
        logic usb_full_speed;
    } pioc_cfg_t;

    typedef struct packed {
        logic prim;
        logic fast;
        logic slow;
        logic pll;
    } pioc_ticks_t;

    typedef struct packed {
        logic usb_ls_ok;
        logic lf_from_fast;
        logic slow_rc_run;
        logic core_on_pll;
        logic locked;
        logic pll_run;
    } pioc_status_t;

endpackage : pioc_pkg

// >>> rtl/pioc_tick_div.sv
`timescale 1ns/100ps
module pioc_tick_div #(
    parameter int W = 4
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_tick,
    input wire logic [W-1:0] i_ratio,
    output logic o_tick
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic tick;
    } pioc_div_state_t;

    pioc_div_state_t s_q;
    pioc_div_state_t s_d;

    // One output pulse for every i_ratio input pulses; ratio 0 acts as 1.
    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (i_tick) begin
            if (s_q.cnt + W'(1) >= i_ratio) begin
                s_d.cnt = '0;
                s_d.tick = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + W'(1);
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_tick = s_q.tick;

endmodule : pioc_tick_div

// >>> rtl/pioc_clk_ctrl.sv
// Behaviour
// RL1: Multiplier runs only in multiplier modes with enable bit 6; 4 to 96 MHz.
// RL2: Eight-setting input prescaler brings 4 MHz multiples down to 4 MHz.
// RL3: Multiplier output is divided to clock both USB and core.
// RL4: Core divider reduces its input by one, two, three or six.
// RL5: Fast oscillator drives core directly and a 31 kHz to 8 MHz postscaler; here the postscaler divides by 1 to 64, and 31 kHz comes from the /256 path.
// RL6: Fast oscillator with multiplier yields core clocks up to 48 MHz.
// RL7: Slow RC runs when selected or any timer or monitor needs it.
// RL8: Internal select field picks fast direct, low-frequency or postscaler.
// RL9: Tuning writes act at once; settling raises no flag.
// RL10: Each trim step changes the frequency by the same amount.
// RL11: Multiplier stays off in every non-multiplier mode.
// RL12: Core keeps its clock until lock, then switches automatically.
// RL13: Bit 7 picks fast oscillator divided by 256, else slow RC.
// RL14: Six-bit trim is signed; zero is centre, 011111 max, 100000 min.
// RL15: Trim affects only the fast oscillator, never the slow RC.
// RL16: USB gets 6 MHz in low speed and 48 MHz in full speed.
// RL17: Low-speed USB needs the core at 24 MHz.
// RL18: Divider codes 11 none, 10 by two, 01 by three, 00 by six.
// RL19: Switching to the multiplier clock never shortens a core clock phase.
`timescale 1ns/100ps
`include "pioc_defines.svh"
module pioc_clk_ctrl #(
    parameter int ADDR_W = 4,
    parameter int LOCK_W = 16,
    parameter int LOCK_CYCLES = `PIOC_LOCK_TIME_US * `PIOC_CLK_FREQ_MHZ
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [7:0] i_wr_data,
    input wire logic i_wr_stb,
    input wire logic i_rd_stb,
    output logic [7:0] o_rd_data,
    input wire pioc_pkg::pioc_cfg_t i_cfg,
    input wire pioc_pkg::pioc_ticks_t i_ticks,
    output logic o_pll_ref_tick,
    output logic o_int_tick,
    output logic o_core_tick,
    output logic o_usb_tick,
    output logic signed [5:0] o_fast_trim,
    output logic [5:0] o_fast_step_code,
    output pioc_pkg::pioc_status_t o_status
);
    import pioc_pkg::*;

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    typedef struct packed {
        logic [7:0] tune;
        logic [7:0] rd_data;
        logic [LOCK_W-1:0] lock_cnt;
        logic pll_run;
        logic locked;
        logic core_on_pll;
        logic slow_run;
        logic lf_from_fast;
        logic int_tick;
        logic usb_tick;
        logic [5:0] step_code;
        logic usb_ls_ok;
    } pioc_state_t;

    pioc_state_t s_q;
    pioc_state_t s_d;

    // ****************************************************************
    // Decoding helpers
    // ****************************************************************

    function automatic logic is_mult_mode(input pioc_osc_mode_t m);
        return m == PIOC_CRYSTAL_MULT || m == PIOC_EXT_CLOCK_MULT ||
               m == PIOC_INTERNAL_MULT || m == PIOC_INTERNAL_MULT_CLKOUT;
    endfunction : is_mult_mode

    function automatic logic is_internal_mode(input pioc_osc_mode_t m);
        return m == PIOC_INTERNAL_MULT || m == PIOC_INTERNAL_MULT_CLKOUT ||
               m == PIOC_INTERNAL || m == PIOC_INTERNAL_CLKOUT;
    endfunction : is_internal_mode

    function automatic logic [3:0] prescale_ratio(input logic [2:0] sel);
        logic [3:0] r;
        r = 4'h1;
        unique case (sel)
            3'h0: r = 4'hc;
            3'h1: r = 4'ha;
            3'h2: r = 4'h6;
            3'h3: r = 4'h5;
            3'h4: r = 4'h4;
            3'h5: r = 4'h3;
            3'h6: r = 4'h2;
            3'h7: r = 4'h1;
        endcase
        return r;
    endfunction : prescale_ratio

    function automatic logic [2:0] core_ratio(input logic [1:0] sel);
        logic [2:0] r;
        r = 3'h1;
        unique case (sel)
            `PIOC_CORE_CLOCK_DIVIDER_SELECT_NONE: r = 3'h1;
            `PIOC_CORE_CLOCK_DIVIDER_SELECT_TWO: r = 3'h2;
            `PIOC_CORE_CLOCK_DIVIDER_SELECT_THREE: r = 3'h3;
            default: r = 3'h6;
        endcase
        return r;
    endfunction : core_ratio

    // Postscaler ratio: 8 MHz divided by 2 to the power (7 - select); select 0 wraps to ratio 0, so no division.
    function automatic logic [6:0] post_ratio(input logic [2:0] sel);
        return 7'h01 << (3'h7 - sel);
    endfunction : post_ratio

    // ****************************************************************
    // Tick dividers
    // ****************************************************************

    logic pre_src;
    logic node48_tick;
    logic usb_ls_tick;
    logic lf_fast_tick;
    logic post_tick;
    logic core_src;
    logic core_tick;

    // Internal multiplier modes feed the fast oscillator to the prescaler.
    assign pre_src = is_internal_mode(i_cfg.mode) ? i_ticks.fast
                                                  : i_ticks.prim;

    pioc_tick_div #(.W(4)) u_prescale ( // RL2
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_tick(pre_src),
        .i_ratio(prescale_ratio(i_cfg.prescale_sel)),
        .o_tick(o_pll_ref_tick)
    );

    pioc_tick_div #(.W(2)) u_node48 ( // RL3
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_tick(i_ticks.pll & s_q.locked),
        .i_ratio(`PIOC_NODE48_DIV),
        .o_tick(node48_tick)
    );

    pioc_tick_div #(.W(4)) u_usb_ls ( // RL16
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_tick(node48_tick),
        .i_ratio(`PIOC_USB_LS_DIV),
        .o_tick(usb_ls_tick)
    );

    pioc_tick_div #(.W(9)) u_lf_fast ( // RL13
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_tick(i_ticks.fast),
        .i_ratio(`PIOC_LF_DIV),
        .o_tick(lf_fast_tick)
    );

    pioc_tick_div #(.W(7)) u_post ( // RL5
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_tick(i_ticks.fast),
        .i_ratio(post_ratio(i_cfg.internal_freq_select)),
        .o_tick(post_tick)
    );

    // Non-internal modes run the core from the primary source before lock.
    assign core_src = s_q.core_on_pll ? node48_tick : // RL6
                      is_internal_mode(i_cfg.mode) ? s_q.int_tick :
                      i_ticks.prim;

    pioc_tick_div #(.W(3)) u_core_div ( // RL4
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_tick(core_src),
        .i_ratio(core_ratio(i_cfg.core_clock_divider_select)), // RL18
        .o_tick(core_tick)
    );

    // ****************************************************************
    // Next state
    // ****************************************************************

    always_comb begin
        s_d = s_q;
        // The write takes effect at once; no busy or done flag exists.
        if (i_wr_stb && i_addr == ADDR_W'(`PIOC_ADDR_TUNING)) begin
            s_d.tune = i_wr_data; // RL9
        end
        s_d.rd_data = 8'h00;
        if (i_rd_stb) begin
            if (i_addr == ADDR_W'(`PIOC_ADDR_TUNING)) begin
                s_d.rd_data = s_q.tune;
            end else if (i_addr == ADDR_W'(`PIOC_ADDR_STATUS)) begin
                s_d.rd_data = {2'h0, o_status};
            end
        end
        s_d.pll_run = is_mult_mode(i_cfg.mode) && // RL11
                      s_q.tune[`PIOC_BIT_MULT_EN]; // RL1
        // Lock timer restarts whenever the multiplier stops.
        if (!s_q.pll_run) begin
            s_d.lock_cnt = '0;
            s_d.locked = 1'b0;
        end else if (!s_q.locked) begin
            if (s_q.lock_cnt + LOCK_W'(1) >= LOCK_W'(LOCK_CYCLES)) begin
                s_d.locked = 1'b1; // RL12
            end else begin
                s_d.lock_cnt = s_q.lock_cnt + LOCK_W'(1);
            end
        end
        // Switch over only right after a core period completes.
        if (!s_q.locked) begin
            s_d.core_on_pll = 1'b0;
        end else if (core_tick) begin
            s_d.core_on_pll = 1'b1; // RL19
        end
        s_d.lf_from_fast = s_q.tune[`PIOC_BIT_LF_SRC];
        if (i_cfg.internal_freq_select == `PIOC_INTERNAL_FREQ_SELECT_LOW) begin // RL8
            s_d.int_tick = s_q.lf_from_fast ? lf_fast_tick // RL13
                                            : i_ticks.slow;
        end else begin
            s_d.int_tick = post_tick;
        end
        s_d.slow_run = (i_cfg.internal_freq_select == `PIOC_INTERNAL_FREQ_SELECT_LOW &&
                        !s_q.lf_from_fast &&
                        is_internal_mode(i_cfg.mode)) ||
                       i_cfg.pwrt_en || i_cfg.fscm_en || // RL7
                       i_cfg.wdt_en || i_cfg.twospd_en;
        s_d.usb_tick = i_cfg.usb_full_speed ? node48_tick // RL16
                                            : usb_ls_tick;
        // Offset binary code: one trim step is one equal analogue step.
        s_d.step_code = s_q.tune[`PIOC_TRIM_MSB:`PIOC_TRIM_LSB] ^
                        `PIOC_TRIM_OFFSET; // RL10
        // Low-speed USB is only legal with the 48 MHz node divided by two.
        s_d.usb_ls_ok = s_q.core_on_pll && // RL17
            i_cfg.core_clock_divider_select == `PIOC_CORE_CLOCK_DIVIDER_SELECT_TWO;
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            s_q <= '0;
            s_q.tune <= `PIOC_TUNE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************

    assign o_rd_data = s_q.rd_data;
    assign o_int_tick = s_q.int_tick;
    assign o_core_tick = core_tick;
    assign o_usb_tick = s_q.usb_tick;
    // The slow RC has no trim input at all.
    assign o_fast_trim = s_q.tune[`PIOC_TRIM_MSB:`PIOC_TRIM_LSB]; // RL14 RL15
    assign o_fast_step_code = s_q.step_code;
    assign o_status.pll_run = s_q.pll_run;
    assign o_status.locked = s_q.locked;
    assign o_status.core_on_pll = s_q.core_on_pll;
    assign o_status.slow_rc_run = s_q.slow_run;
    assign o_status.lf_from_fast = s_q.lf_from_fast;
    assign o_status.usb_ls_ok = s_q.usb_ls_ok;

    // ****************************************************************
    // Checks
    // ****************************************************************

    pll_off_a: assert property ( // RL11
        !is_mult_mode(i_cfg.mode) |=> !o_status.pll_run)
        else $error("multiplier running in a plain mode");

    pll_on_a: assert property ( // RL1
        is_mult_mode(i_cfg.mode) && s_q.tune[`PIOC_BIT_MULT_EN]
        |=> o_status.pll_run)
        else $error("multiplier not started");

    lock_wait_a: assert property ( // RL12
        $rose(o_status.pll_run) |-> !o_status.locked [*8])
        else $error("lock reported too early");

    core_src_a: assert property ( // RL12
        !o_status.locked |=> !o_status.core_on_pll)
        else $error("core on multiplier without lock");

    switch_a: assert property ( // RL19
        $rose(o_status.core_on_pll) |-> $past(core_tick))
        else $error("switch not at period end");

    slow_run_a: assert property ( // RL7
        i_cfg.wdt_en || i_cfg.pwrt_en |=> o_status.slow_rc_run)
        else $error("slow oscillator not running");

    rd_lat_a: assert property ( // RL9
        i_rd_stb && i_addr == ADDR_W'(`PIOC_ADDR_TUNING) && !i_wr_stb
        |=> o_rd_data == $past(s_q.tune))
        else $error("tuning read wrong");

    trim_out_a: assert property ( // RL14
        $past(i_wr_stb) && $past(i_addr) == ADDR_W'(`PIOC_ADDR_TUNING)
        |-> o_fast_trim == $signed($past(i_wr_data[5:0])))
        else $error("trim not applied");

    // The node divider may keep a partial count across a relock.
    usb_lock_a: assert property ( // RL16
        o_usb_tick |-> $past(o_status.locked, 2) ||
        $past(o_status.locked, 3))
        else $error("usb clock without lock");

    step_mid_a: assert property ( // RL10
        o_fast_trim == 6'sh00 |=> o_fast_step_code == `PIOC_TRIM_OFFSET
        || $changed(o_fast_trim))
        else $error("centre code wrong");

    step_code_a: assert property ( // RL10
        1'b1 |=> o_fast_step_code ==
        ($past(o_fast_trim) ^ `PIOC_TRIM_OFFSET))
        else $error("step code does not follow trim");

    rd_idle_a: assert property ( // RL9
        !i_rd_stb |=> o_rd_data == 8'h00)
        else $error("read data without a read");

    lf_src_a: assert property ( // RL13
        1'b1 |=> o_status.lf_from_fast ==
        $past(s_q.tune[`PIOC_BIT_LF_SRC]))
        else $error("low-frequency source wrong");

    usb_ls_a: assert property ( // RL17
        o_status.core_on_pll &&
        i_cfg.core_clock_divider_select == `PIOC_CORE_CLOCK_DIVIDER_SELECT_TWO
        |=> o_status.usb_ls_ok)
        else $error("low-speed flag missing");

    slow_sel_a: assert property ( // RL7
        is_internal_mode(i_cfg.mode) && !o_status.lf_from_fast &&
        i_cfg.internal_freq_select == `PIOC_INTERNAL_FREQ_SELECT_LOW
        |=> o_status.slow_rc_run)
        else $error("selected slow oscillator not running");

    int_src_a: assert property ( // RL8
        i_cfg.internal_freq_select != `PIOC_INTERNAL_FREQ_SELECT_LOW
        |=> o_int_tick == $past(post_tick))
        else $error("postscaler not selected");

endmodule : pioc_clk_ctrl

// >>> sim/pioc_tick_src.sv
`timescale 1ns/100ps
// ****************************************************************
// Oscillator tick sources; a period of zero holds a source still.
// ****************************************************************
module pioc_tick_src (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic [3:0][9:0] i_period,
    output pioc_pkg::pioc_ticks_t o_ticks
);
    import pioc_pkg::*;
    logic [3:0][9:0] cnt_q;
    always_ff @(posedge i_clk_sys) begin
        for (int k = 0; k < 4; k++) begin
            if (!i_rst_n || i_period[k] == 10'h000 ||
                cnt_q[k] >= i_period[k] - 10'h001) begin
                cnt_q[k] <= 10'h000;
            end else begin
                cnt_q[k] <= cnt_q[k] + 10'h001;
            end
        end
    end
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            o_ticks[k] = i_rst_n && i_period[k] != 10'h000 &&
                         cnt_q[k] == i_period[k] - 10'h001;
        end
    end
endmodule : pioc_tick_src

// >>> sim/testbench.sv
`timescale 1ns/100ps
`include "pioc_defines.svh"
module testbench;
    import pioc_pkg::*;
    localparam int LOCK = 20;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdat = 8'h00;
    logic wr = 1'b0;
    logic rd_s = 1'b0;
    logic [7:0] rdat;
    pioc_cfg_t cfg = '0;
    pioc_ticks_t ticks;
    logic [3:0][9:0] per = '0;
    logic ref_t, int_t, core_t, usb_t;
    logic signed [5:0] trim;
    logic [5:0] step;
    pioc_status_t st;
    int error_cnt = 0;
    int checks_done = 0;
    int cyc = 0;
    int div_tab[8] = '{12, 10, 6, 5, 4, 3, 2, 1};
    always #25 clk = ~clk;
    pioc_tick_src i_src (.i_clk_sys(clk), .i_rst_n(rst_n),
        .i_period(per), .o_ticks(ticks));
    pioc_clk_ctrl #(.LOCK_CYCLES(LOCK)) i_dut (.i_clk_sys(clk),
        .i_rst_n(rst_n), .i_addr(addr), .i_wr_data(wdat), .i_wr_stb(wr),
        .i_rd_stb(rd_s), .o_rd_data(rdat), .i_cfg(cfg), .i_ticks(ticks),
        .o_pll_ref_tick(ref_t), .o_int_tick(int_t), .o_core_tick(core_t),
        .o_usb_tick(usb_t), .o_fast_trim(trim), .o_fast_step_code(step),
        .o_status(st));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic summarize();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : summarize
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            summarize();
        end
    end
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdat <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        check(32'(rdat), 32'(e));
        @(posedge clk);
        #1;
        check(32'(rdat), 32'h0000_0000);
    endtask : rd_reg
    function automatic logic pick(input int s);
        logic [3:0] v;
        v = {ref_t, int_t, core_t, usb_t};
        return v[s];
    endfunction : pick
    // Spacing between the second and third tick of one output.
    task automatic gap(input int s, input int e);
        int n;
        int m;
        int t;
        n = 0;
        m = 0;
        t = 0;
        while (t < 3 && n < 2000) begin
            @(posedge clk);
            #1;
            n++;
            if (pick(s) === 1'b1) begin
                t++;
                if (t == 2) m = n;
            end
        end
        check(32'(n - m), 32'(e));
    endtask : gap
    task automatic t_regs();
        logic [7:0] tv[3] = '{8'h1F, 8'h20, 8'h00};
        rd_reg(`PIOC_ADDR_TUNING, `PIOC_TUNE_RST);
        wr_reg(`PIOC_ADDR_TUNING, 8'hBF);
        rd_reg(`PIOC_ADDR_TUNING, 8'hBF);
        wr_reg(`PIOC_ADDR_STATUS, 8'hFF);
        rd_reg(`PIOC_ADDR_TUNING, 8'hBF);
        rd_reg(4'hF, 8'h00);
        for (int i = 0; i < 3; i++) begin
            wr_reg(`PIOC_ADDR_TUNING, tv[i]);
            repeat (2) @(posedge clk);
            #1;
            check(32'(trim), 32'($signed(tv[i][5:0])));
            check(32'(step), 32'(tv[i][5:0] ^ 6'h20));
        end
    endtask : t_regs
    task automatic t_prescale();
        cfg.mode <= PIOC_CRYSTAL_MULT;
        per[3] <= 10'h001;
        for (int i = 0; i < 8; i++) begin
            cfg.prescale_sel <= 3'(i);
            gap(3, div_tab[i]);
        end
    endtask : t_prescale
    task automatic t_core();
        cfg.mode <= PIOC_CRYSTAL;
        wr_reg(`PIOC_ADDR_TUNING, 8'h40);
        repeat (3) @(posedge clk);
        #1;
        check(32'(st.pll_run), 32'h0000_0000);
        cfg.core_clock_divider_select <= `PIOC_CORE_CLOCK_DIVIDER_SELECT_NONE;
        gap(1, 1);
        cfg.core_clock_divider_select <= `PIOC_CORE_CLOCK_DIVIDER_SELECT_TWO;
        gap(1, 2);
        cfg.core_clock_divider_select <= `PIOC_CORE_CLOCK_DIVIDER_SELECT_THREE;
        gap(1, 3);
        cfg.core_clock_divider_select <= 2'h0;
        gap(1, 6);
    endtask : t_core
    task automatic t_lock();
        int n;
        cfg.mode <= PIOC_CRYSTAL_MULT;
        cfg.prescale_sel <= 3'h7;
        cfg.core_clock_divider_select <= `PIOC_CORE_CLOCK_DIVIDER_SELECT_NONE;
        cfg.usb_full_speed <= 1'b1;
        per[0] <= 10'h001;
        wr_reg(`PIOC_ADDR_TUNING, 8'h00);
        repeat (4) @(posedge clk);
        wr_reg(`PIOC_ADDR_TUNING, 8'h40);
        rd_reg(`PIOC_ADDR_STATUS, 8'h01);
        check(32'(st.core_on_pll), 32'h0000_0000);
        n = 0;
        while (st.core_on_pll !== 1'b1 && n < 200) begin
            @(posedge clk);
            #1;
            n++;
        end
        check(32'(st.core_on_pll), 32'h0000_0001);
        check(32'(st.locked), 32'h0000_0001);
        gap(1, 2);
        gap(0, 2);
        cfg.usb_full_speed <= 1'b0;
        cfg.core_clock_divider_select <= `PIOC_CORE_CLOCK_DIVIDER_SELECT_TWO;
        gap(0, 16);
        gap(1, 4);
        check(32'(st.usb_ls_ok), 32'h0000_0001);
    endtask : t_lock
    task automatic t_int();
        cfg.mode <= PIOC_INTERNAL_MULT;
        cfg.prescale_sel <= 3'h4;
        per[3] <= 10'h000;
        per[2] <= 10'h001;
        per[1] <= 10'h007;
        wr_reg(`PIOC_ADDR_TUNING, 8'h80);
        gap(3, 4);
        check(32'(st.lf_from_fast), 32'h0000_0001);
        cfg.mode <= PIOC_INTERNAL;
        for (int i = 1; i < 8; i++) begin
            cfg.internal_freq_select <= 3'(i);
            gap(2, 1 << (7 - i));
        end
        cfg.internal_freq_select <= `PIOC_INTERNAL_FREQ_SELECT_LOW;
        gap(2, 256);
        wr_reg(`PIOC_ADDR_TUNING, 8'h1F);
        gap(2, 7);
        check(32'(st.slow_rc_run), 32'h0000_0001);
        check(32'(st.lf_from_fast), 32'h0000_0000);
        wr_reg(`PIOC_ADDR_TUNING, 8'h20);
        gap(2, 7);
    endtask : t_int
    task automatic t_slow();
        cfg.mode <= PIOC_CRYSTAL;
        cfg.internal_freq_select <= 3'h3;
        for (int k = 0; k < 5; k++) begin
            {cfg.pwrt_en, cfg.fscm_en, cfg.wdt_en, cfg.twospd_en} <=
                4'(5'h01 << k);
            repeat (3) @(posedge clk);
            #1;
            check(32'(st.slow_rc_run), 32'(k < 4));
        end
    endtask : t_slow
    task automatic t_modes();
        wr_reg(`PIOC_ADDR_TUNING, 8'h40);
        for (int m = 0; m < 8; m++) begin
            cfg.mode <= pioc_osc_mode_t'(m);
            repeat (3) @(posedge clk);
            #1;
            check(32'(st.pll_run), 32'(m < 4));
        end
        cfg.mode <= PIOC_CRYSTAL;
    endtask : t_modes
    task automatic t_reset();
        wr_reg(`PIOC_ADDR_TUNING, 8'hC5);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rd_reg(`PIOC_ADDR_TUNING, `PIOC_TUNE_RST);
        rd_reg(`PIOC_ADDR_STATUS, 8'h00);
        check(32'(step), 32'(`PIOC_TRIM_OFFSET));
    endtask : t_reset
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_prescale();
        t_core();
        t_modes();
        t_lock();
        t_int();
        t_slow();
        t_reset();
        summarize();
    end
endmodule : testbench
